/* verilog/deviation_monitor_params.svh */
// constants for the following-error monitor
`ifndef DEVIATION_MONITOR_PARAMS_SVH
`define DEVIATION_MONITOR_PARAMS_SVH
`define LIMIT_LOW_RESET      16'h0000
`define LIMIT_HIGH_RESET     16'h0000
`define PERSIST_TIME_RESET   16'h0000
`define LIMIT_DISABLE_HALF   16'hFFFF
`define STATUS_FOLLOW_ERR_BIT 13
`define OBJ_FOLLOW_WINDOW    16'h6065
`define OBJ_FOLLOW_TIMEOUT   16'h6066
`define OBJ_STATUSWORD       16'h6041
`define TICK_TIME_NS         20
`define TICK_CYCLES          1
`endif

/* verilog/deviation_monitor_pkg.sv */
// types for the following-error monitor
package deviation_monitor_pkg;
  typedef enum logic [1:0] {
    MON_IDLE   = 2'b00,
    MON_TIMING = 2'b01,
    MON_FAULT  = 2'b11
  } mon_state_t;

  typedef enum logic [1:0] {
    UNIT_PULSE     = 2'b00,
    UNIT_MILLIDEG  = 2'b01
  } unit_sel_t;
endpackage

/* verilog/param_word_reg.sv */
// one 16-bit parameter word with link override over tool write
`timescale 1ns/1ns
module param_word_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // writers
  input  wire logic        link_we_i,
  input  wire logic [15:0] link_data_i,
  input  wire logic        tool_we_i,
  input  wire logic [15:0] tool_data_i,
  // value
  output logic [15:0]      value_o
);
  logic [15:0] value_nxt;

  assign value_nxt = link_we_i ? link_data_i :
                     tool_we_i ? tool_data_i : value_o;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      value_o <= RESET_VAL;
    end else begin
      value_o <= value_nxt;
    end
  end
endmodule

/* verilog/following_error_monitor.sv */
// following-error monitor with its parameter words and status flag
`timescale 1ns/1ns
`include "deviation_monitor_params.svh"
module following_error_monitor #(
  parameter int TIME_W = 16
) (
  // clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      rst_b_i,
  // position loop
  input  wire logic [31:0]               droop_count_i,
  input  wire logic                      profile_pos_mode_i,
  input  wire deviation_monitor_pkg::unit_sel_t param_position_unit_select_i,
  // cyclic link writes
  input  wire logic                      link_we_i,
  input  wire logic [15:0]               link_index_i,
  input  wire logic                      link_sub_i,
  input  wire logic [15:0]               link_data_i,
  // configuration tool writes
  input  wire logic                      tool_we_low_i,
  input  wire logic                      tool_we_high_i,
  input  wire logic                      tool_we_time_i,
  input  wire logic [15:0]               tool_data_i,
  // parameter readback
  output logic [15:0]                    param_deviation_limit_low_o,
  output logic [15:0]                    param_deviation_limit_high_o,
  output logic [15:0]                    param_deviation_persist_time_o,
  output deviation_monitor_pkg::unit_sel_t limit_unit_o,
  // status
  output logic                           following_error_o,
  output logic [15:0]                    statusword_o
);
  import deviation_monitor_pkg::*;

  logic [15:0] deviation_limit_low;
  logic [15:0] deviation_limit_high;
  logic [15:0] deviation_persist_time;
  logic [TIME_W-1:0] timer_r;
  logic [TIME_W-1:0] timer_nxt;
  mon_state_t  state_r;
  mon_state_t  state_nxt;
  logic        flag_nxt;

  wire hit_window  = link_we_i && (link_index_i == `OBJ_FOLLOW_WINDOW);
  wire we_link_low  = hit_window && !link_sub_i;
  wire we_link_high = hit_window && link_sub_i;
  wire we_link_time = link_we_i && (link_index_i == `OBJ_FOLLOW_TIMEOUT);

  param_word_reg #(.RESET_VAL(`LIMIT_LOW_RESET)) u_low (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .link_we_i   (we_link_low),
    .link_data_i (link_data_i),
    .tool_we_i   (tool_we_low_i),
    .tool_data_i (tool_data_i),
    .value_o     (deviation_limit_low)
  );
  param_word_reg #(.RESET_VAL(`LIMIT_HIGH_RESET)) u_high (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .link_we_i   (we_link_high),
    .link_data_i (link_data_i),
    .tool_we_i   (tool_we_high_i),
    .tool_data_i (tool_data_i),
    .value_o     (deviation_limit_high)
  );
  param_word_reg #(.RESET_VAL(`PERSIST_TIME_RESET)) u_time (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .link_we_i   (we_link_time),
    .link_data_i (link_data_i),
    .tool_we_i   (tool_we_time_i),
    .tool_data_i (tool_data_i),
    .value_o     (deviation_persist_time)
  );

  wire [31:0] threshold = {deviation_limit_high, deviation_limit_low};
  wire disabled = (deviation_limit_high == `LIMIT_DISABLE_HALF) &&
                  (deviation_limit_low == `LIMIT_DISABLE_HALF);
  wire enabled = profile_pos_mode_i && !disabled;
  wire excess = enabled && (droop_count_i > threshold);
  wire [TIME_W-1:0] limit_ticks = deviation_persist_time[TIME_W-1:0];
  wire timer_done = (timer_r >= limit_ticks);

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    flag_nxt  = 1'b0;
    unique case (state_r)
      MON_IDLE: begin
        timer_nxt = '0;
        if (excess && limit_ticks == '0) begin
          state_nxt = MON_FAULT;
          flag_nxt  = 1'b1;
        end else if (excess) begin
          state_nxt = MON_TIMING;
          timer_nxt = TIME_W'(1);
        end
      end
      MON_TIMING: begin
        if (!excess) begin
          state_nxt = MON_IDLE;
          timer_nxt = '0;
        end else if (timer_done) begin
          state_nxt = MON_FAULT;
          flag_nxt  = 1'b1;
        end else begin
          timer_nxt = timer_r + TIME_W'(`TICK_CYCLES);
        end
      end
      MON_FAULT: begin
        if (!excess) begin
          state_nxt = MON_IDLE;
          timer_nxt = '0;
        end else begin
          flag_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = MON_IDLE;
        timer_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_r           <= MON_IDLE;
      timer_r           <= '0;
      following_error_o <= 1'b0;
      statusword_o      <= 16'h0000;
    end else begin
      state_r           <= state_nxt;
      timer_r           <= timer_nxt;
      following_error_o <= flag_nxt;
      statusword_o      <= 16'(flag_nxt) << `STATUS_FOLLOW_ERR_BIT;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      param_deviation_limit_low_o    <= `LIMIT_LOW_RESET;
      param_deviation_limit_high_o   <= `LIMIT_HIGH_RESET;
      param_deviation_persist_time_o <= `PERSIST_TIME_RESET;
      limit_unit_o                   <= UNIT_PULSE;
    end else begin
      param_deviation_limit_low_o    <= deviation_limit_low;
      param_deviation_limit_high_o   <= deviation_limit_high;
      param_deviation_persist_time_o <= deviation_persist_time;
      limit_unit_o                   <= param_position_unit_select_i;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_excess_run;
    excess [*2];
  endsequence

  // an excess cycle followed by a quiet cycle
  sequence s_dip;
    excess ##1 !excess;
  endsequence

  chk_strict_compare: assert property (!(droop_count_i > threshold) |=> !following_error_o)
    else $error("flag with droop not above threshold");
  chk_zero_immediate: assert property (
    excess && limit_ticks == '0 && state_r == MON_IDLE |=> following_error_o)
    else $error("zero time did not fire at once");
  chk_no_early_flag: assert property ($rose(excess) && limit_ticks >= 16'd2 |=> !following_error_o)
    else $error("flag before filtering time");
  chk_flag_after_one: assert property (
    $rose(excess) && limit_ticks == 16'd1 ##1 excess |=> following_error_o)
    else $error("flag missing after filtering time");
  chk_disable_all_ones: assert property (disabled |=> !following_error_o)
    else $error("flag while disabled");
  chk_mode_gate: assert property (!profile_pos_mode_i |=> !following_error_o)
    else $error("flag outside profile position");
  chk_clear_timer: assert property (!excess |=> timer_r == '0 && state_r == MON_IDLE)
    else $error("timer not restarted");
  chk_link_override: assert property (
    we_link_low && tool_we_low_i |=> deviation_limit_low == $past(link_data_i))
    else $error("tool write beat link write");
  chk_status_bit: assert property (statusword_o[`STATUS_FOLLOW_ERR_BIT] == following_error_o)
    else $error("statusword bit mismatch");
  chk_hold_run: assert property ((following_error_o ##0 s_excess_run) |-> following_error_o)
    else $error("flag dropped during excess");
  chk_window_write: assert property (we_link_high |=> deviation_limit_high == $past(link_data_i))
    else $error("window high not written");
  chk_time_write: assert property (we_link_time |=> deviation_persist_time == $past(link_data_i))
    else $error("timeout object not written");
  chk_other_low: assert property (
    link_we_i && !hit_window && !tool_we_low_i |=> deviation_limit_low == $past(deviation_limit_low))
    else $error("low half changed by other object");
  chk_other_high: assert property (
    link_we_i && !hit_window && !tool_we_high_i |=> deviation_limit_high == $past(deviation_limit_high))
    else $error("high half changed by other object");
  chk_readback_lag: assert property (param_deviation_persist_time_o == $past(deviation_persist_time))
    else $error("timeout readback not one cycle behind");
  chk_rise_excess: assert property ($rose(following_error_o) |-> $past(excess))
    else $error("flag rose without excess");
  chk_dip_restart: assert property (s_dip |=> timer_r == '0 && !following_error_o)
    else $error("timer not restarted after dip");
endmodule

/* tb/link_master.sv */
// cyclic link controller model writing mapped objects
`timescale 1ns/1ns
module link_master (
  // clock
  input  wire logic   mclk_i,
  // link writes
  output logic        link_we_o,
  output logic [15:0] link_index_o,
  output logic        link_sub_o,
  output logic [15:0] link_data_o
);
  initial begin
    link_we_o = 1'b0;
    link_index_o = 16'h0000;
    link_sub_o = 1'b0;
    link_data_o = 16'h0000;
  end
  task automatic write(input logic [15:0] idx, input logic sub, input logic [15:0] dat);
    @(posedge mclk_i);
    link_we_o <= 1'b1;
    link_index_o <= idx;
    link_sub_o <= sub;
    link_data_o <= dat;
    @(posedge mclk_i);
    link_we_o <= 1'b0;
    link_index_o <= ~idx;
    link_sub_o <= ~sub;
    link_data_o <= ~dat;
  endtask
endmodule

/* tb/following_error_monitor_tb.sv */
// testbench for the following-error monitor
`timescale 1ns/1ns
`include "deviation_monitor_params.svh"
module following_error_monitor_tb;
  import deviation_monitor_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [31:0] droop_count_i = 32'h0000_0000;
  logic        profile_pos_mode_i = 1'b0;
  unit_sel_t   param_position_unit_select_i = UNIT_PULSE;
  logic        tool_we_low_i = 1'b0, tool_we_high_i = 1'b0, tool_we_time_i = 1'b0;
  logic [15:0] tool_data_i = 16'h0000;
  logic        link_we_i, link_sub_i, following_error_o;
  logic [15:0] link_index_i, link_data_i, statusword_o;
  logic [15:0] param_deviation_limit_low_o, param_deviation_limit_high_o, param_deviation_persist_time_o;
  unit_sel_t   limit_unit_o;
  int          bad_count = 0, checked = 0, cycles = 0;
  typedef struct {logic [31:0] lim; logic [15:0] tm; logic [31:0] dr; logic md; logic fl;} row_t;
  row_t rows [5] = '{'{32'h0001_2345, 16'h0000, 32'h0001_2345, 1'b1, 1'b0},
                     '{32'h0001_2345, 16'h0000, 32'h0001_2346, 1'b1, 1'b1},
                     '{32'h0000_FFFF, 16'h0002, 32'h0001_0000, 1'b1, 1'b1},
                     '{32'h0000_0010, 16'h0002, 32'h8000_0000, 1'b0, 1'b0},
                     '{32'hFFFF_FFFF, 16'h0001, 32'hFFFF_FFFF, 1'b1, 1'b0}};
  always #10 mclk_i = ~mclk_i;
  link_master ctl (.mclk_i, .link_we_o(link_we_i), .link_index_o(link_index_i), .link_sub_o(link_sub_i),
                   .link_data_o(link_data_i));
  following_error_monitor uut (.mclk_i, .rst_b_i, .droop_count_i, .profile_pos_mode_i,
    .param_position_unit_select_i, .link_we_i, .link_index_i, .link_sub_i, .link_data_i, .tool_we_low_i,
    .tool_we_high_i, .tool_we_time_i, .tool_data_i, .param_deviation_limit_low_o, .param_deviation_limit_high_o,
    .param_deviation_persist_time_o, .limit_unit_o, .following_error_o, .statusword_o);
  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic exp);
    checked++;
    if (following_error_o !== exp) begin
      bad_count++;
      $display("mismatch at %0t: flag %b, expected %b", $time, following_error_o, exp);
    end
    cmp_word(statusword_o, {2'b00, exp, 13'h0000});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic setin(input logic [31:0] d, input logic m);
    @(posedge mclk_i);
    droop_count_i <= d;
    profile_pos_mode_i <= m;
  endtask
  task automatic set_limit(input logic [31:0] lim, input logic [15:0] tm);
    ctl.write(`OBJ_FOLLOW_WINDOW, 1'b0, lim[15:0]);
    ctl.write(`OBJ_FOLLOW_WINDOW, 1'b1, lim[31:16]);
    ctl.write(`OBJ_FOLLOW_TIMEOUT, 1'b0, tm);
    tick(2);
  endtask
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      setin(32'h0000_0000, 1'b1);
      set_limit(rows[i].lim, rows[i].tm);
      cmp_word(param_deviation_limit_low_o, rows[i].lim[15:0]);
      cmp_word(param_deviation_limit_high_o, rows[i].lim[31:16]);
      cmp_word(param_deviation_persist_time_o, rows[i].tm);
      setin(rows[i].dr, rows[i].md);
      tick(rows[i].tm + 3);
      cmp_flag(rows[i].fl);
    end
    setin(32'h0000_0000, 1'b1);
    set_limit(32'h0000_0100, 16'h0004);
    for (int k = 0; k < 2; k++) begin
      setin(32'h0000_0101, 1'b1);
      tick(4);
      cmp_flag(1'b0);
      tick(3);
      cmp_flag(1'b1);
      setin(32'h0000_0100, 1'b1);
      tick(2);
      cmp_flag(1'b0);
    end
    setin(32'h0000_0101, 1'b1);
    tick(2);
    setin(32'h0000_0100, 1'b1);
    setin(32'h0000_0101, 1'b1);
    tick(4);
    cmp_flag(1'b0);
    tick(1);
    cmp_flag(1'b1);
    setin(32'h0000_0100, 1'b1);
    set_limit(32'h0000_0100, 16'h0001);
    setin(32'h0000_0101, 1'b1);
    tick(1);
    cmp_flag(1'b0);
    tick(1);
    cmp_flag(1'b1);
    setin(32'h0000_0100, 1'b1);
    ctl.write(`OBJ_STATUSWORD, 1'b0, 16'hABCD);
    tick(2);
    cmp_word(param_deviation_limit_low_o, 16'h0100);
    @(posedge mclk_i);
    tool_we_time_i <= 1'b1;
    tool_data_i <= 16'h0007;
    param_position_unit_select_i <= UNIT_MILLIDEG;
    @(posedge mclk_i);
    tool_we_time_i <= 1'b0;
    tick(2);
    cmp_word(param_deviation_persist_time_o, 16'h0007);
    cmp_word({14'h0000, limit_unit_o}, {14'h0000, UNIT_MILLIDEG});
    fork
      ctl.write(`OBJ_FOLLOW_WINDOW, 1'b0, 16'h0055);
      begin
        @(posedge mclk_i);
        tool_we_low_i <= 1'b1;
        tool_data_i <= 16'h00AA;
        @(posedge mclk_i);
        tool_we_low_i <= 1'b0;
      end
    join
    tick(2);
    cmp_word(param_deviation_limit_low_o, 16'h0055);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    tick(2);
    cmp_word(param_deviation_limit_low_o, `LIMIT_LOW_RESET);
    cmp_word(param_deviation_persist_time_o, `PERSIST_TIME_RESET);
    cmp_flag(1'b0);
    give_verdict;
  end
endmodule
